/* rtl/mfe_regs.sv */
// What this block does
// - Bit 7 of the bias register resets to 0 and, when set, requests device software power-down.
// - With the override bit clear, bias stays off while detection is on and no headset is in.
// - The two-bit bias level selects off, 2 V, 2.5 V or the analog supply, resetting to off.
// - Gain bit 7 resets to 1 and forces 0 dB; clear, the amplifier follows the gain code.
// - The seven-bit gain code steps by 0.5 dB from 0 dB up to 59.5 dB at code 0x77, reset 0.
// - Each input code 00 disconnects and 01, 10, 11 connect through 10, 20 or 40 kilohm.
// - The positive routing register has three two-bit fields at 7:6, 5:4 and 3:2, reset 00.
// - The negative routing register routes the common-mode reference at 7:6 and mic at 5:4.
// - Any nonzero input code connects its source, and several inputs may be active at once.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "mfe_defs.svh"

module mfe_regs (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  mfe_pkg::mfe_axil_req_t     axi_req_i,
  output mfe_pkg::mfe_axil_rsp_t     axi_rsp_o,
  input  wire logic                  hs_detect_en_i,
  input  wire logic                  hs_present_i,
  output mfe_pkg::mfe_ana_ctrl_t     ana_ctrl_o,
  output mfe_pkg::mfe_route_t [2:0]  pos_route_o,
  output mfe_pkg::mfe_route_t [1:0]  neg_route_o
);
  import mfe_pkg::*;

  localparam int AW = `MFE_AXI_ADDR_W;
  localparam int DW = `MFE_AXI_DATA_W;

  // Everything this block remembers.
  typedef struct packed {
    // Write channel sequencer and the half of a write that arrived first.
    mfe_wr_state_t wr_state;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          wr_lane0;
    logic [1:0]    bresp;
    // Read channel sequencer and the word it answers with.
    mfe_rd_state_t rd_state;
    logic [7:0]    rdata;
    logic [1:0]    rresp;
    // Stored register fields; reserved bits have no storage at all.
    logic          pwr_down;
    logic          bias_ovr;
    logic [1:0]    bias_lvl;
    logic          gain_force;
    logic [6:0]    gain_code;
    logic [1:0]    pos_left;
    logic [1:0]    pos_right;
    logic [1:0]    pos_neg;
    logic [1:0]    neg_ref;
    logic [1:0]    neg_mic;
    // Controls toward the analog side, registered so they never glitch.
    logic          bias_on;
    logic [1:0]    bias_lvl_eff;
    logic [6:0]    gain_eff;
  } mfe_state_t;

  mfe_state_t st_r;
  mfe_state_t st_nxt;

  // Image of the four registers as they read back.
  logic [7:0] bias_img;
  logic [7:0] gain_img;
  logic [7:0] pos_img;
  logic [7:0] neg_img;

  // Maps a byte address to a register; only aligned words inside the map hit.
  function automatic mfe_sel_t addr_sel(input logic [AW-1:0] addr);
    logic [AW-3:0] word;
    word = addr[AW-1:2];
    if (addr[1:0] != 2'h0) begin
      addr_sel = MFE_SEL_NONE;
    end else if (word == (AW-2)'(`MFE_IDX_BIAS)) begin
      addr_sel = MFE_SEL_BIAS;
    end else if (word == (AW-2)'(`MFE_IDX_GAIN)) begin
      addr_sel = MFE_SEL_GAIN;
    end else if (word == (AW-2)'(`MFE_IDX_POS_ROUTE)) begin
      addr_sel = MFE_SEL_POS;
    end else if (word == (AW-2)'(`MFE_IDX_NEG_ROUTE)) begin
      addr_sel = MFE_SEL_NEG;
    end else begin
      addr_sel = MFE_SEL_NONE;
    end
  endfunction

  // Reserved bits are not stored, so they always read back as zero.
  // read back
  always_comb begin
    bias_img = 8'h00;
    bias_img[`MFE_BIAS_PWRDN_BIT]                    = st_r.pwr_down;
    bias_img[`MFE_BIAS_OVR_BIT]                      = st_r.bias_ovr;
    bias_img[`MFE_BIAS_LVL_LSB+1:`MFE_BIAS_LVL_LSB]  = st_r.bias_lvl;
    gain_img = 8'h00;
    gain_img[`MFE_GAIN_FORCE_BIT]                    = st_r.gain_force;
    gain_img[`MFE_GAIN_CODE_LSB+6:`MFE_GAIN_CODE_LSB] = st_r.gain_code;
    pos_img = 8'h00;
    pos_img[`MFE_POS_LEFT_LSB+1:`MFE_POS_LEFT_LSB]   = st_r.pos_left;
    pos_img[`MFE_POS_RIGHT_LSB+1:`MFE_POS_RIGHT_LSB] = st_r.pos_right;
    pos_img[`MFE_POS_NEG_LSB+1:`MFE_POS_NEG_LSB]     = st_r.pos_neg;
    neg_img = 8'h00;
    neg_img[`MFE_NEG_REF_LSB+1:`MFE_NEG_REF_LSB]     = st_r.neg_ref;
    neg_img[`MFE_NEG_MIC_LSB+1:`MFE_NEG_MIC_LSB]     = st_r.neg_mic;
  end

  // Next state: bus sequencers, register updates and the derived controls.
  always_comb begin
    logic          wr_fire;
    logic [AW-1:0] wr_a;
    logic [7:0]    wr_d;
    logic          wr_l0;
    mfe_sel_t      wsel;
    mfe_sel_t      rsel;
    logic          bias_gate;
    wr_fire   = 1'b0;
    wr_a      = st_r.wr_addr;
    wr_d      = st_r.wr_data;
    wr_l0     = st_r.wr_lane0;
    wsel      = MFE_SEL_NONE;
    rsel      = MFE_SEL_NONE;
    bias_gate = 1'b0;
    st_nxt    = st_r;

    // Address and data are taken in either order; the write happens on the
    // edge that completes the pair, so the register never sees half a write.
    case (st_r.wr_state)
      MFE_WR_IDLE: begin
        if (axi_req_i.awvalid && axi_req_i.wvalid) begin
          wr_fire = 1'b1;
          wr_a    = axi_req_i.awaddr;
          wr_d    = axi_req_i.wdata[7:0];
          wr_l0   = axi_req_i.wstrb[0];
          st_nxt.wr_state = MFE_WR_RESP;
        end else if (axi_req_i.awvalid) begin
          st_nxt.wr_addr  = axi_req_i.awaddr;
          st_nxt.wr_state = MFE_WR_ADDR;
        end else if (axi_req_i.wvalid) begin
          st_nxt.wr_data  = axi_req_i.wdata[7:0];
          st_nxt.wr_lane0 = axi_req_i.wstrb[0];
          st_nxt.wr_state = MFE_WR_DATA;
        end
      end
      MFE_WR_ADDR: begin
        if (axi_req_i.wvalid) begin
          wr_fire = 1'b1;
          wr_d    = axi_req_i.wdata[7:0];
          wr_l0   = axi_req_i.wstrb[0];
          st_nxt.wr_state = MFE_WR_RESP;
        end
      end
      MFE_WR_DATA: begin
        if (axi_req_i.awvalid) begin
          wr_fire = 1'b1;
          wr_a    = axi_req_i.awaddr;
          st_nxt.wr_state = MFE_WR_RESP;
        end
      end
      MFE_WR_RESP: begin
        if (axi_req_i.bready) begin
          st_nxt.wr_state = MFE_WR_IDLE;
        end
      end
      default: begin
        st_nxt.wr_state = MFE_WR_IDLE;
      end
    endcase

    // Only byte lane 0 carries register bits; a write without it changes
    // nothing but still answers OKAY. Unmapped addresses answer SLVERR.
    if (wr_fire) begin
      wsel = addr_sel(wr_a);
      st_nxt.bresp = (wsel == MFE_SEL_NONE) ? `MFE_RESP_SLVERR : `MFE_RESP_OKAY;
      if (wr_l0) begin
        case (wsel)
          MFE_SEL_BIAS: begin
            st_nxt.pwr_down = wr_d[`MFE_BIAS_PWRDN_BIT];
            st_nxt.bias_ovr = wr_d[`MFE_BIAS_OVR_BIT];
            st_nxt.bias_lvl = wr_d[`MFE_BIAS_LVL_LSB+1:`MFE_BIAS_LVL_LSB];
          end
          MFE_SEL_GAIN: begin
            st_nxt.gain_force = wr_d[`MFE_GAIN_FORCE_BIT];
            st_nxt.gain_code  = wr_d[`MFE_GAIN_CODE_LSB+6:`MFE_GAIN_CODE_LSB];
          end
          MFE_SEL_POS: begin
            st_nxt.pos_left  = wr_d[`MFE_POS_LEFT_LSB+1:`MFE_POS_LEFT_LSB];
            st_nxt.pos_right = wr_d[`MFE_POS_RIGHT_LSB+1:`MFE_POS_RIGHT_LSB];
            st_nxt.pos_neg   = wr_d[`MFE_POS_NEG_LSB+1:`MFE_POS_NEG_LSB];
          end
          MFE_SEL_NEG: begin
            st_nxt.neg_ref = wr_d[`MFE_NEG_REF_LSB+1:`MFE_NEG_REF_LSB];
            st_nxt.neg_mic = wr_d[`MFE_NEG_MIC_LSB+1:`MFE_NEG_MIC_LSB];
          end
          default: begin
            st_nxt.pwr_down = st_r.pwr_down;
          end
        endcase
      end
    end

    // A read taken together with a write returns the value before the write.
    case (st_r.rd_state)
      MFE_RD_IDLE: begin
        if (axi_req_i.arvalid) begin
          rsel = addr_sel(axi_req_i.araddr);
          st_nxt.rresp    = `MFE_RESP_OKAY;
          st_nxt.rd_state = MFE_RD_RESP;
          case (rsel)
            MFE_SEL_BIAS: st_nxt.rdata = bias_img;
            MFE_SEL_GAIN: st_nxt.rdata = gain_img;
            MFE_SEL_POS:  st_nxt.rdata = pos_img;
            MFE_SEL_NEG:  st_nxt.rdata = neg_img;
            default: begin
              st_nxt.rdata = 8'h00;
              st_nxt.rresp = `MFE_RESP_SLVERR;
            end
          endcase
        end
      end
      MFE_RD_RESP: begin
        if (axi_req_i.rready) begin
          st_nxt.rd_state = MFE_RD_IDLE;
        end
      end
      default: begin
        st_nxt.rd_state = MFE_RD_IDLE;
      end
    endcase

    // Headset gating is re-evaluated every cycle from the stored fields, so
    // a headset change reaches the bias one edge later.
    // headset gating
    bias_gate = !st_r.bias_ovr && hs_detect_en_i && !hs_present_i;
    st_nxt.bias_on      = (st_r.bias_lvl != MFE_BIAS_OFF) && !bias_gate;
    st_nxt.bias_lvl_eff = bias_gate ? MFE_BIAS_OFF : st_r.bias_lvl;
    // The applied gain follows the fields being written this edge, so the
    // force flag and the applied gain never disagree for a cycle.
    // forced 0 dB
    st_nxt.gain_eff = st_nxt.gain_force ? 7'h00 : st_nxt.gain_code;
  end

  // Reset values of every field; the controls start in the off state.
  // The two top bits are cut from the reset words so they cannot drift apart.
  localparam mfe_state_t ST_RST = '{
    wr_state:     MFE_WR_IDLE,
    wr_addr:      '0,
    wr_data:      8'h00,
    wr_lane0:     1'b0,
    bresp:        `MFE_RESP_OKAY,
    rd_state:     MFE_RD_IDLE,
    rdata:        8'h00,
    rresp:        `MFE_RESP_OKAY,
    pwr_down:     1'(`MFE_RST_BIAS >> `MFE_BIAS_PWRDN_BIT),
    bias_ovr:     1'b0,
    bias_lvl:     2'h0,
    gain_force:   1'(`MFE_RST_GAIN >> `MFE_GAIN_FORCE_BIT),
    gain_code:    7'h00,
    pos_left:     2'h0,
    pos_right:    2'h0,
    pos_neg:      2'h0,
    neg_ref:      2'h0,
    neg_mic:      2'h0,
    bias_on:      1'b0,
    bias_lvl_eff: 2'h0,
    gain_eff:     7'h00
  };

  // Single state register with synchronous reset.
  // reset values
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus handshakes follow the sequencer states directly.
  // Decoding them from state keeps every input-to-output path out of the bus.
  always_comb begin
    axi_rsp_o         = '0;
    axi_rsp_o.awready = (st_r.wr_state == MFE_WR_IDLE) || (st_r.wr_state == MFE_WR_DATA);
    axi_rsp_o.wready  = (st_r.wr_state == MFE_WR_IDLE) || (st_r.wr_state == MFE_WR_ADDR);
    axi_rsp_o.bvalid  = (st_r.wr_state == MFE_WR_RESP);
    axi_rsp_o.bresp   = st_r.bresp;
    axi_rsp_o.arready = (st_r.rd_state == MFE_RD_IDLE);
    axi_rsp_o.rvalid  = (st_r.rd_state == MFE_RD_RESP);
    axi_rsp_o.rdata   = DW'(st_r.rdata);
    axi_rsp_o.rresp   = st_r.rresp;
  end

  // Bias and gain controls. A reserved gain code is passed on as written;
  // the flag lets the analog side clamp it rather than guess.
  // half-dB steps
  always_comb begin
    ana_ctrl_o               = '0;
    ana_ctrl_o.sw_power_down = st_r.pwr_down;
    ana_ctrl_o.bias_on       = st_r.bias_on;
    ana_ctrl_o.bias_level    = mfe_bias_lvl_t'(st_r.bias_lvl_eff);
    ana_ctrl_o.gain_forced   = st_r.gain_force;
    ana_ctrl_o.gain_half_db  = st_r.gain_eff;
    ana_ctrl_o.gain_code_bad = st_r.gain_eff > `MFE_GAIN_CODE_MAX;
  end

  // Each input is decoded on its own, so any mix of inputs can be live.
  // independent inputs
  mfe_route_dec #(.CODE_W(2)) u_pos_left (
    .code_i  (st_r.pos_left),
    .route_o (pos_route_o[0])
  );

  mfe_route_dec #(.CODE_W(2)) u_pos_right (
    .code_i  (st_r.pos_right),
    .route_o (pos_route_o[1])
  );

  mfe_route_dec #(.CODE_W(2)) u_pos_neg (
    .code_i  (st_r.pos_neg),
    .route_o (pos_route_o[2])
  );

  mfe_route_dec #(.CODE_W(2)) u_neg_ref (
    .code_i  (st_r.neg_ref),
    .route_o (neg_route_o[0])
  );

  mfe_route_dec #(.CODE_W(2)) u_neg_mic (
    .code_i  (st_r.neg_mic),
    .route_o (neg_route_o[1])
  );

endmodule

/* rtl/mfe_route_dec.sv */
`timescale 1ns/1ns

// Turns one two-bit routing code into a connect flag and a one-hot
// resistance choice. The resistance lines are all low while unconnected.
module mfe_route_dec #(
  parameter int CODE_W = 2
) (
  input  wire logic [CODE_W-1:0] code_i,
  output mfe_pkg::mfe_route_t    route_o
);
  import mfe_pkg::*;

  // Any nonzero code connects the source.
  always_comb begin
    route_o         = '0;
    route_o.connect = |code_i;
    route_o.res_10k = (code_i == CODE_W'(1));
    route_o.res_20k = (code_i == CODE_W'(2));
    route_o.res_40k = (code_i == CODE_W'(3));
  end

endmodule

/* shared/mfe_defs.svh */
`ifndef MFE_DEFS_SVH
`define MFE_DEFS_SVH

// Bus geometry of the register slave.
`define MFE_AXI_ADDR_W     12
`define MFE_AXI_DATA_W     32

// Register indices as printed; the byte address is four times the index.
`define MFE_IDX_BIAS       8'h2E
`define MFE_IDX_GAIN       8'h2F
`define MFE_IDX_POS_ROUTE  8'h30
`define MFE_IDX_NEG_ROUTE  8'h31

// Field positions in the bias and power control register.
`define MFE_BIAS_PWRDN_BIT 7
`define MFE_BIAS_OVR_BIT   3
`define MFE_BIAS_LVL_LSB   0

// Field positions in the amplifier gain register.
`define MFE_GAIN_FORCE_BIT 7
`define MFE_GAIN_CODE_LSB  0

// Field positions in the two input routing registers.
`define MFE_POS_LEFT_LSB   6
`define MFE_POS_RIGHT_LSB  4
`define MFE_POS_NEG_LSB    2
`define MFE_NEG_REF_LSB    6
`define MFE_NEG_MIC_LSB    4

// Reset values of the four registers.
`define MFE_RST_BIAS       8'h00
`define MFE_RST_GAIN       8'h80
`define MFE_RST_POS_ROUTE  8'h00
`define MFE_RST_NEG_ROUTE  8'h00

// Highest gain code that names a defined gain step.
`define MFE_GAIN_CODE_MAX  7'h77

// Bus response codes.
`define MFE_RESP_OKAY      2'h0
`define MFE_RESP_SLVERR    2'h2

`endif

/* shared/mfe_pkg.sv */
`include "mfe_defs.svh"

package mfe_pkg;

  // Signals driven by the bus master.
  typedef struct packed {
    logic                          awvalid;
    logic [`MFE_AXI_ADDR_W-1:0]    awaddr;
    logic [2:0]                    awprot;
    logic                          wvalid;
    logic [`MFE_AXI_DATA_W-1:0]    wdata;
    logic [`MFE_AXI_DATA_W/8-1:0]  wstrb;
    logic                          bready;
    logic                          arvalid;
    logic [`MFE_AXI_ADDR_W-1:0]    araddr;
    logic [2:0]                    arprot;
    logic                          rready;
  } mfe_axil_req_t;

  // Signals driven by the register slave.
  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [`MFE_AXI_DATA_W-1:0]    rdata;
    logic [1:0]                    rresp;
  } mfe_axil_rsp_t;

  // Write channel sequencer states.
  typedef enum logic [3:0] {
    MFE_WR_IDLE = 4'h1,
    MFE_WR_ADDR = 4'h2,
    MFE_WR_DATA = 4'h4,
    MFE_WR_RESP = 4'h8
  } mfe_wr_state_t;

  // Read channel sequencer states.
  typedef enum logic [1:0] {
    MFE_RD_IDLE = 2'h1,
    MFE_RD_RESP = 2'h2
  } mfe_rd_state_t;

  // Microphone bias output levels.
  typedef enum logic [1:0] {
    MFE_BIAS_OFF    = 2'h0,
    MFE_BIAS_2V0    = 2'h1,
    MFE_BIAS_2V5    = 2'h2,
    MFE_BIAS_SUPPLY = 2'h3
  } mfe_bias_lvl_t;

  // Register selected by a bus address.
  typedef enum logic [4:0] {
    MFE_SEL_NONE = 5'h01,
    MFE_SEL_BIAS = 5'h02,
    MFE_SEL_GAIN = 5'h04,
    MFE_SEL_POS  = 5'h08,
    MFE_SEL_NEG  = 5'h10
  } mfe_sel_t;

  // Decoded routing of one input to an amplifier terminal.
  typedef struct packed {
    logic connect;
    logic res_10k;
    logic res_20k;
    logic res_40k;
  } mfe_route_t;

  // Bias and gain controls for the analog front end.
  typedef struct packed {
    logic          sw_power_down;
    logic          bias_on;
    mfe_bias_lvl_t bias_level;
    logic          gain_forced;
    logic [6:0]    gain_half_db;
    logic          gain_code_bad;
  } mfe_ana_ctrl_t;

endpackage

/* verif/mfe_host_model.sv */
`timescale 1ns/1ns

// Host side of the register bus; handshakes are judged at the falling edge so
// the decision never races the slave's own update at the rising edge.
module mfe_host_model (
  input  logic                    clk_sys_i,
  output mfe_pkg::mfe_axil_req_t  req_o,
  input  mfe_pkg::mfe_axil_rsp_t  rsp_i
);
  import mfe_pkg::*;

  initial req_o = '0;

  function automatic logic [7:0] legal(input logic [11:0] a, input logic [7:0] d);
    case (a)
      12'hB8: legal = d & 8'h8B;
      12'hBC: legal = (d[6:0] > 7'h77) ? {d[7], 7'h77} : d;
      12'hC0: legal = d & 8'hFC;
      12'hC4: legal = d & 8'hF0;
      default: legal = d;
    endcase
  endfunction

  // Offers address and data together and holds each until it is taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r, output bit hung);
    bit ha, hw, hb;
    ha = 0;
    hw = 0;
    hb = 0;
    r = 2'h3;
    @(posedge clk_sys_i);
    req_o.awaddr <= a;
    req_o.wdata <= {24'h0, legal(a, d)};
    req_o.wstrb <= s;
    req_o.awvalid <= 1'b1;
    req_o.wvalid <= 1'b1;
    req_o.bready <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge clk_sys_i);
      ha = req_o.awvalid && rsp_i.awready;
      hw = req_o.wvalid && rsp_i.wready;
      hb = rsp_i.bvalid;
      r = rsp_i.bresp;
      @(posedge clk_sys_i);
      if (ha) req_o.awvalid <= 1'b0;
      if (hw) req_o.wvalid <= 1'b0;
      if (hb) req_o.bready <= 1'b0;
    end
    hung = !hb;
  endtask

  // Holds the read address until taken and rready until data arrives.
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit hung);
    bit ha, hr;
    ha = 0;
    hr = 0;
    r = 2'h3;
    d = '0;
    @(posedge clk_sys_i);
    req_o.araddr <= a;
    req_o.arvalid <= 1'b1;
    req_o.rready <= 1'b1;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge clk_sys_i);
      ha = req_o.arvalid && rsp_i.arready;
      hr = rsp_i.rvalid;
      d = rsp_i.rdata;
      r = rsp_i.rresp;
      @(posedge clk_sys_i);
      if (ha) req_o.arvalid <= 1'b0;
      if (hr) req_o.rready <= 1'b0;
    end
    hung = !hr;
  endtask
endmodule

/* verif/mfe_regs_properties.sv */
`timescale 1ns/1ns

// Watches the register slave from its ports only; one clock domain throughout.
module mfe_regs_properties (
  input logic                          clk_sys_i,
  input logic                          nrst_i,
  input mfe_pkg::mfe_axil_req_t        axi_req_i,
  input mfe_pkg::mfe_axil_rsp_t        axi_rsp_o,
  input logic                          hs_detect_en_i,
  input logic                          hs_present_i,
  input mfe_pkg::mfe_ana_ctrl_t        ana_ctrl_o,
  input mfe_pkg::mfe_route_t [2:0]     pos_route_o,
  input mfe_pkg::mfe_route_t [1:0]     neg_route_o
);
  import mfe_pkg::*;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // A decoded route must connect exactly when one resistance line is chosen.
  function automatic logic rt_ok(input mfe_route_t r);
    rt_ok = (r.connect == (r.res_10k | r.res_20k | r.res_40k)) &&
            $onehot0({r.res_10k, r.res_20k, r.res_40k});
  endfunction

  // Both halves of a write taken at one edge, and a read taken.
  sequence s_wr_take;
    axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
  endsequence
  sequence s_rd_take;
    axi_req_i.arvalid && axi_rsp_o.arready;
  endsequence

  a_wr_answer: assert property (s_wr_take |=> axi_rsp_o.bvalid && !axi_rsp_o.awready)
    else $error("write response late or address still accepted");
  a_rd_answer: assert property (s_rd_take |=> axi_rsp_o.rvalid && !axi_rsp_o.arready)
    else $error("read response late or address still accepted");
  a_bresp_stands: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=>
      axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
    else $error("write response dropped before acceptance");
  a_rdata_stands: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=>
      axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("read data dropped before acceptance");
  a_rdata_narrow: assert property (axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_force_zero: assert property (ana_ctrl_o.gain_forced |-> ana_ctrl_o.gain_half_db == 7'h00)
    else $error("forced gain not reported as zero");
  a_code_flag: assert property (ana_ctrl_o.gain_code_bad == (ana_ctrl_o.gain_half_db > 7'h77))
    else $error("gain code flag disagrees with code");
  a_bias_on_lvl: assert property (ana_ctrl_o.bias_on == (ana_ctrl_o.bias_level != MFE_BIAS_OFF))
    else $error("bias enable disagrees with level");
  a_route_shape: assert property (rt_ok(pos_route_o[0]) && rt_ok(pos_route_o[1]) &&
      rt_ok(pos_route_o[2]) && rt_ok(neg_route_o[0]) && rt_ok(neg_route_o[1]))
    else $error("route decode malformed");
  a_reset_vals: assert property ($rose(nrst_i) |-> ana_ctrl_o.gain_forced &&
      !ana_ctrl_o.sw_power_down && !ana_ctrl_o.bias_on)
    else $error("controls wrong after reset");
endmodule

bind mfe_regs mfe_regs_properties i_props (
  .clk_sys_i      (clk_sys_i),
  .nrst_i         (nrst_i),
  .axi_req_i      (axi_req_i),
  .axi_rsp_o      (axi_rsp_o),
  .hs_detect_en_i (hs_detect_en_i),
  .hs_present_i   (hs_present_i),
  .ana_ctrl_o     (ana_ctrl_o),
  .pos_route_o    (pos_route_o),
  .neg_route_o    (neg_route_o)
);

/* verif/testbench.sv */
`timescale 1ns/1ns

module testbench;
  import mfe_pkg::*;

  logic                clk_sys_i;
  logic                nrst_i;
  logic                hs_det;
  logic                hs_pres;
  mfe_axil_req_t       req;
  mfe_axil_rsp_t       rsp;
  mfe_ana_ctrl_t       ana;
  mfe_route_t [2:0]    pos;
  mfe_route_t [1:0]    neg;
  int                  error_cnt = 0;
  int                  checks = 0;
  integer              seed = 75663;
  logic [7:0]          shadow [4];
  logic [7:0]          gv [6] = '{8'h00, 8'h01, 8'h76, 8'h77, 8'hD5, 8'h80};
  logic [1:0]          lv;

  mfe_regs i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .hs_detect_en_i(hs_det), .hs_present_i(hs_pres), .ana_ctrl_o(ana), .pos_route_o(pos),
    .neg_route_o(neg));
  mfe_host_model i_host (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));

  // Free-running system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A bus wait that ran out counts as a mismatch and ends the run.
  task automatic hang(input bit h);
    if (h) begin
      error_cnt++;
      final_report();
    end
  endtask

  // Index 4 lands just past the map, so it must be refused.
  // A strobe without byte lane 0 must leave the register as it was.
  task automatic wreg(input int i, input logic [7:0] d, input logic [3:0] s = 4'hF);
    logic [1:0] r;
    bit h;
    i_host.wr(12'hB8 + 12'(4 * i), d, s, r, h);
    hang(h);
    chk(r, (i < 4) ? 2'h0 : 2'h2);
    if (i < 4 && s[0]) shadow[i] = i_host.legal(12'hB8 + 12'(4 * i), d);
    @(negedge clk_sys_i);
  endtask

  task automatic rreg(input int i);
    logic [31:0] d;
    logic [1:0] r;
    bit h;
    i_host.rd(12'hB8 + 12'(4 * i), d, r, h);
    hang(h);
    chk(r, (i < 4) ? 2'h0 : 2'h2);
    chk(d, (i < 4) ? {24'h0, shadow[i]} : 32'h0);
  endtask

  // Expected decode of one routing code: connect, then 10k, 20k, 40k.
  function automatic logic [3:0] rt(input logic [1:0] c);
    rt = (c == 2'h0) ? 4'h0 : {1'b1, c == 2'h1, c == 2'h2, c == 2'h3};
  endfunction

  initial begin
    nrst_i = 1'b0;
    hs_det = 1'b0;
    hs_pres = 1'b0;
    shadow = '{8'h00, 8'h80, 8'h00, 8'h00};
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(ana.gain_forced, 1'b1);
    chk(pos, 12'h0);
    chk(neg, 8'h0);
    // reset values, then random traffic with refused addresses mixed in.
    for (int i = 0; i < 4; i++) rreg(i);
    for (int n = 0; n < 30; n++) begin
      wreg($unsigned($random(seed)) % 5, 8'($random(seed)));
      rreg($unsigned($random(seed)) % 5);
    end
    // every level under each override, presence and detection case.
    for (int l = 0; l < 4; l++) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge clk_sys_i);
        hs_det <= !k[2];
        hs_pres <= k[1];
        wreg(0, {1'b1, 3'h0, k[0], 1'b0, 2'(l)});
        lv = (k[0] || k[1] || k[2]) ? 2'(l) : 2'h0;
        chk(ana.bias_level, lv);
        chk(ana.bias_on, lv != 2'h0);
        chk(ana.sw_power_down, 1'b1);
      end
    end
    wreg(0, 8'h03);
    chk(ana.sw_power_down, 1'b0);
    // gain ends and the force bit.
    foreach (gv[j]) begin
      wreg(1, gv[j]);
      chk(ana.gain_forced, gv[j][7]);
      chk(ana.gain_half_db, gv[j][7] ? 7'h00 : gv[j][6:0]);
      chk(ana.gain_code_bad, 1'b0);
    end
    // a write without byte lane 0 answers OKAY and changes nothing.
    wreg(1, 8'h12, 4'hE);
    rreg(1);
    chk(ana.gain_forced, 1'b1);
    // all codes in every field, several inputs at once.
    for (int c = 0; c < 16; c++) begin
      wreg(2, {c[1:0], c[3:2], c[1:0] ^ c[3:2], 2'h0});
      wreg(3, {c[3:2], c[1:0], 4'h0});
      chk(pos[0], rt(c[1:0]));
      chk(pos[1], rt(c[3:2]));
      chk(pos[2], rt(c[1:0] ^ c[3:2]));
      chk(neg[0], rt(c[3:2]));
      chk(neg[1], rt(c[1:0]));
      rreg(2);
    end
    final_report();
  end
endmodule
